/* fwp_pkg.sv */
package fwp_pkg;

  // ********************************************************************
  // Register offsets (plain register port)
  // ********************************************************************
  localparam logic [2:0] ADDR_TIMING    = 3'h3;
  localparam logic [2:0] ADDR_LOW       = 3'h4;
  localparam logic [2:0] ADDR_HIGH      = 3'h5;
  localparam logic [2:0] ADDR_CONTROL   = 3'h6;
  localparam logic [2:0] ADDR_DATA      = 3'h7;
  localparam logic [2:0] ADDR_MISC      = 3'h0;

  // ********************************************************************
  // Control and misc register fields
  // ********************************************************************
  localparam int CTL_ERASE_BIT   = 0;
  localparam int CTL_PROGRAM_BIT = 1;
  localparam int CTL_BUSY_BIT    = 7;
  localparam int CTL_PENDING_BIT = 6;
  localparam int MISC_CHIP_ERASE_BIT = 0;
  localparam int MISC_CPU_ACCESS_BIT = 1;
  localparam int MISC_VIOLATION_BIT  = 2;

  // ********************************************************************
  // Reset values, geometry and DMA trigger code
  // ********************************************************************
  localparam logic [5:0] TIMING_RESET = 6'h11;
  localparam int PAGE_BYTES      = 1024;
  localparam int PAGE_WORDS      = 512;
  localparam int WORD_ADDR_BITS  = 14;
  localparam logic [7:0] DMA_TRIGGER_CODE = 8'h12;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int CLK_MHZ            = 25;
  localparam int PAGE_ERASE_US      = 20000;
  localparam int CHIP_ERASE_US      = 200000;
  localparam int WORD_PROGRAM_US    = 20;
  localparam int DATA_TIMEOUT_US    = 40;
  localparam int PAGE_ERASE_CYCLES  = PAGE_ERASE_US * CLK_MHZ;
  localparam int CHIP_ERASE_CYCLES  = CHIP_ERASE_US * CLK_MHZ;
  localparam int WORD_PROGRAM_CYCLES = WORD_PROGRAM_US * CLK_MHZ;
  localparam int DATA_TIMEOUT_CYCLES = DATA_TIMEOUT_US * CLK_MHZ;

  // ********************************************************************
  // Sequencer states
  // ********************************************************************
  typedef enum logic [2:0] {
    FWP_IDLE    = 3'b000,
    FWP_ERASE   = 3'b001,
    FWP_WAITLO  = 3'b010,
    FWP_WAITHI  = 3'b011,
    FWP_PROGRAM = 3'b100,
    FWP_CHIPERS = 3'b101
  } fwp_state_t;

endpackage : fwp_pkg

/* fwp_timer.sv */
`timescale 1ns/1ns
module fwp_timer
  import fwp_pkg::*;
#(
  parameter int WIDTH = 23
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] count,
  output logic                  done
);

  initial begin
    if (WIDTH < 2) $error("fwp_timer width too small");
  end

  logic [WIDTH-1:0] remaining;
  logic             running;

  // Load restarts the count; done pulses once when it runs out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      remaining <= '0;
      running   <= 1'b0;
      done      <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        remaining <= count;
        running   <= 1'b1;
      end else if (running) begin
        remaining <= remaining - 1'b1;
        if (remaining <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
          running <= 1'b0;
          done    <= 1'b1;
        end
      end
    end
  end

endmodule : fwp_timer

/* fwp_array.sv */
`timescale 1ns/1ns
module fwp_array
  import fwp_pkg::*;
#(
  parameter int PAGES = 32
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      prog_en,
  input  wire logic [WORD_ADDR_BITS-1:0] prog_addr,
  input  wire logic [15:0]               prog_data,
  input  wire logic                      page_erase,
  input  wire logic [4:0]                page_sel,
  input  wire logic                      chip_erase,
  input  wire logic [WORD_ADDR_BITS-1:0] rd_addr,
  output logic [15:0]                    rd_data
);

  localparam int WORDS = PAGES * PAGE_WORDS;

  initial begin
    if (PAGES != 8 && PAGES != 16 && PAGES != 32) $error("fwp_array page count unsupported");
  end

  logic [15:0] mem [WORDS];

  // Programming only pulls bits low; erase or reset is the only way back to ones
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < WORDS; i++) mem[i] <= 16'hFFFF;
    end else begin
      for (int i = 0; i < WORDS; i++) begin
        if (chip_erase || (page_erase && (i / PAGE_WORDS) == int'(page_sel)))
          mem[i] <= 16'hFFFF;
        else if (prog_en && int'(prog_addr) == i)
          mem[i] <= mem[i] & prog_data;
      end
    end
  end

  assign rd_data = (int'(rd_addr) < WORDS) ? mem[rd_addr] : 16'hFFFF;

endmodule : fwp_array

/* fwp_controller.sv */
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
module fwp_controller
  import fwp_pkg::*;
#(
  parameter int PAGES              = 32,
  parameter int PAGE_ERASE_CNT     = PAGE_ERASE_CYCLES,
  parameter int CHIP_ERASE_CNT     = CHIP_ERASE_CYCLES,
  parameter int DATA_TIMEOUT_CNT   = DATA_TIMEOUT_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [2:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic [7:0]       reg_rdata,
  input  wire logic [2:0]  cpu_clock_divider,
  input  wire logic        cpu_fetch,
  input  wire logic [15:0] cpu_byte_addr,
  output logic [7:0]       cpu_fetch_data,
  output logic             cpu_fetch_valid,
  output logic             dma_trigger,
  output logic [7:0]       dma_trigger_select,
  output logic             array_powered,
  output logic             nvm_busy,
  output logic             word_program_pending
);

  localparam int TW = 23;

  initial begin
    if (PAGE_ERASE_CNT < 1 || CHIP_ERASE_CNT < 1 || DATA_TIMEOUT_CNT < 1)
      $error("fwp_controller counts must be positive");
    if (CHIP_ERASE_CNT >= (1 << TW) || PAGE_ERASE_CNT >= (1 << TW))
      $error("fwp_controller counts exceed timer width");
  end

  // ********************************************************************
  // Reset synchroniser
  // ********************************************************************
  logic rst_meta;
  logic rst_n;

  // Two stages so release never lands near a clock edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ********************************************************************
  // Registers and state
  // ********************************************************************
  fwp_state_t       state;
  fwp_state_t       next_state;
  logic [5:0]       timing;
  logic [7:0]       addr_low_byte;
  logic [7:0]       addr_high_byte;
  logic [7:0]       low_latch;
  logic [7:0]       program_data_port;
  logic             prog_request;
  logic             violation;
  logic             chip_erase_req;
  logic             fetch_hold;
  logic [TW-1:0]    timer_count;
  logic             timer_load;
  logic             timer_done;
  logic [15:0]      array_rdata;

  // ********************************************************************
  // Decode
  // ********************************************************************
  wire wr_ctl   = reg_write && reg_addr == ADDR_CONTROL;
  wire wr_data  = reg_write && reg_addr == ADDR_DATA;
  wire wr_misc  = reg_write && reg_addr == ADDR_MISC;
  wire idle     = state == FWP_IDLE;
  wire set_prog = wr_ctl && reg_wdata[CTL_PROGRAM_BIT] && idle;
  wire set_ers  = wr_ctl && reg_wdata[CTL_ERASE_BIT] && idle;
  wire set_chip = wr_misc && reg_wdata[MISC_CHIP_ERASE_BIT] && idle;
  wire [WORD_ADDR_BITS-1:0] word_addr = {addr_high_byte[5:0], addr_low_byte};
  wire [4:0] page_sel = addr_high_byte[5:1];
  wire       in_wait  = state == FWP_WAITLO || state == FWP_WAITHI;
  wire       word_complete = wr_data && state == FWP_WAITHI;
  wire       pending  = state == FWP_PROGRAM;
  wire       busy     = !idle;
  wire [WORD_ADDR_BITS-1:0] fetch_word = cpu_byte_addr[WORD_ADDR_BITS:1];
  wire       fetch_ok = cpu_fetch && !pending && !fetch_hold;

  // ********************************************************************
  // Sequencer next state
  // ********************************************************************
  always_comb begin
    next_state  = state;
    timer_load  = 1'b0;
    timer_count = TW'(DATA_TIMEOUT_CNT);
    unique case (state)
      FWP_IDLE: begin
        if (set_chip) begin
          next_state  = FWP_CHIPERS;
          timer_load  = 1'b1;
          timer_count = TW'(CHIP_ERASE_CNT);
        end else if (set_ers) begin
          next_state  = FWP_ERASE;
          timer_load  = 1'b1;
          timer_count = TW'(PAGE_ERASE_CNT);
        end else if (set_prog) begin
          next_state  = FWP_WAITLO;
          timer_load  = 1'b1;
        end
      end
      FWP_ERASE, FWP_CHIPERS: begin
        if (timer_done) begin
          next_state = prog_request ? FWP_WAITLO : FWP_IDLE;
          timer_load = prog_request;
        end
      end
      FWP_WAITLO, FWP_WAITHI: begin
        if (word_complete) begin
          next_state  = FWP_PROGRAM;
          timer_load  = 1'b1;
          timer_count = TW'(WORD_PROGRAM_CYCLES);
        end else if (wr_data) begin
          next_state = FWP_WAITHI;
        end else if (timer_done) begin
          next_state = FWP_IDLE;
        end
      end
      FWP_PROGRAM: begin
        if (timer_done) begin
          next_state = FWP_WAITLO;
          timer_load = 1'b1;
        end
      end
      default: next_state = FWP_IDLE;
    endcase
  end

  fwp_timer #(.WIDTH(TW)) u_timer (
    .clk   (clk),
    .rst_n (rst_n),
    .load  (timer_load),
    .count (timer_count),
    .done  (timer_done)
  );

  fwp_array #(.PAGES(PAGES)) u_array (
    .clk        (clk),
    .rst_n      (rst_n),
    .prog_en    (word_complete),
    .prog_addr  (word_addr),
    .prog_data  ({reg_wdata, low_latch}),
    .page_erase (state == FWP_ERASE && timer_done),
    .page_sel   (page_sel),
    .chip_erase (state == FWP_CHIPERS && timer_done),
    .rd_addr    (fetch_word),
    .rd_data    (array_rdata)
  );

  // ********************************************************************
  // State and register updates
  // ********************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= FWP_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Address registers; software writes only land while idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_low_byte  <= 8'h00;
      addr_high_byte <= 8'h00;
    end else if (state == FWP_PROGRAM && timer_done) begin
      {addr_high_byte[5:0], addr_low_byte} <= word_addr + 1'b1;
    end else if (reg_write && idle) begin
      if (reg_addr == ADDR_LOW) addr_low_byte <= reg_wdata;
      if (reg_addr == ADDR_HIGH) addr_high_byte <= reg_wdata;
    end
  end

  // Data port, timing and request bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timing            <= TIMING_RESET;
      low_latch         <= 8'h00;
      program_data_port <= 8'h00;
      prog_request      <= 1'b0;
      chip_erase_req    <= 1'b0;
    end else begin
      if (reg_write && reg_addr == ADDR_TIMING) timing <= reg_wdata[5:0];
      if (wr_data) program_data_port <= reg_wdata;
      if (wr_data && state == FWP_WAITLO) low_latch <= reg_wdata;
      if (idle) prog_request <= set_prog;
      chip_erase_req <= state == FWP_CHIPERS;
    end
  end

  // access violation, set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      violation <= 1'b0;
    end else if (cpu_fetch && pending) begin
      violation <= 1'b1;
    end else if (wr_misc && reg_wdata[MISC_VIOLATION_BIT]) begin
      violation <= 1'b0;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  wire [7:0] ctl_read  = {busy, pending, 6'h00};
  wire [7:0] misc_read = {5'h00, violation, fetch_hold, chip_erase_req};
  wire [7:0] rd_mux =
    reg_addr == ADDR_CONTROL ? ctl_read :
    reg_addr == ADDR_LOW     ? addr_low_byte :
    reg_addr == ADDR_HIGH    ? addr_high_byte :
    reg_addr == ADDR_TIMING  ? {2'b00, timing} :
    reg_addr == ADDR_DATA    ? program_data_port :
    reg_addr == ADDR_MISC    ? misc_read : 8'h00;
  // port ready for byte, first trigger on start
  wire dma_trigger_select_next = (set_prog && !set_ers && !set_chip) ||
                   (in_wait && wr_data && !word_complete) ||
                   ((state == FWP_PROGRAM || state == FWP_ERASE) && timer_done &&
                    (state == FWP_PROGRAM || prog_request));

  // Registered outputs; read data stand only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata            <= 8'h00;
      cpu_fetch_data       <= 8'h00;
      cpu_fetch_valid      <= 1'b0;
      dma_trigger          <= 1'b0;
      dma_trigger_select   <= 8'h00;
      array_powered        <= 1'b0;
      nvm_busy             <= 1'b0;
      word_program_pending <= 1'b0;
      fetch_hold           <= 1'b0;
    end else begin
      reg_rdata          <= reg_read ? rd_mux : 8'h00;
      fetch_hold         <= 1'b0;
      cpu_fetch_valid    <= fetch_ok;
      cpu_fetch_data     <= cpu_byte_addr[0] ? array_rdata[15:8] : array_rdata[7:0];
      dma_trigger        <= dma_trigger_select_next;
      dma_trigger_select <= DMA_TRIGGER_CODE;
      // power down between reads when divided and idle
      array_powered      <= (cpu_clock_divider == 3'b000) || cpu_fetch || busy;
      nvm_busy             <= busy;
      word_program_pending <= pending;
    end
  end

endmodule : fwp_controller

/* fwp_controller_monitor.sv */
`timescale 1ns/1ns
module fwp_controller_monitor
  import fwp_pkg::*;
#(
  parameter int DATA_TIMEOUT_CNT = DATA_TIMEOUT_CYCLES
) (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       cpu_fetch_valid,
  input wire logic       dma_trigger,
  input wire logic [7:0] dma_trigger_select,
  input wire logic       nvm_busy,
  input wire logic       word_program_pending
);
  // ****************************************
  // Decodes and idle counter
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Program start without erase; an erase would delay the first trigger
  wire start_wr = reg_write && (reg_addr == ADDR_CONTROL) && reg_wdata[CTL_PROGRAM_BIT]
                  && !reg_wdata[CTL_ERASE_BIT] && !nvm_busy;
  wire data_wr  = reg_write && (reg_addr == ADDR_DATA);
  logic [15:0] idle_cnt;
  // Busy cycles outside word programming with no data write, erase included; bounds the data timeout
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) idle_cnt <= 16'h0000;
    else if (!nvm_busy || word_program_pending || data_wr) idle_cnt <= 16'h0000;
    else idle_cnt <= idle_cnt + 16'h0001;
  end
  a_start_trigger: assert property (start_wr |=> dma_trigger)
    else $error("no trigger after start");
  a_trigger_pulse: assert property (dma_trigger |=> !dma_trigger)
    else $error("trigger longer than one cycle");
  a_trigger_busy: assert property (dma_trigger |=> nvm_busy)
    else $error("trigger outside an operation");
  a_pending_hold: assert property ($rose(word_program_pending) |-> word_program_pending[*8])
    else $error("pending flag too short");
  a_pending_busy: assert property (word_program_pending |-> nvm_busy)
    else $error("pending without busy");
  a_fetch_refused: assert property (word_program_pending |-> !cpu_fetch_valid)
    else $error("fetch served while programming");
  a_trigger_code: assert property ($past(resetn, 4) |-> dma_trigger_select == DMA_TRIGGER_CODE)
    else $error("wrong trigger code");
  // The trigger launches on the word-done edge, the registered pending flag one edge later,
  // so the trigger pulse sits one cycle before pending is seen low
  a_retrigger: assert property ($fell(word_program_pending) && nvm_busy |-> $past(dma_trigger))
    else $error("no trigger after word done");
  a_timeout_bound: assert property (idle_cnt <= DATA_TIMEOUT_CNT + 4)
    else $error("busy outlived the data timeout");
endmodule : fwp_controller_monitor

bind fwp_controller fwp_controller_monitor #(.DATA_TIMEOUT_CNT(DATA_TIMEOUT_CNT)) u_mon (
  .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .cpu_fetch_valid(cpu_fetch_valid), .dma_trigger(dma_trigger),
  .dma_trigger_select(dma_trigger_select), .nvm_busy(nvm_busy),
  .word_program_pending(word_program_pending)
);

/* fwp_dma_model.sv */
`timescale 1ns/1ns
module fwp_dma_model
  import fwp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       dma_trigger,
  input  wire logic [7:0] dma_trigger_select,
  input  wire logic       armed,
  input  wire logic [3:0] lag,
  input  wire logic [7:0] count,
  output logic            dma_write,
  output logic [7:0]      dma_wdata
);
  logic [7:0] sent;
  logic [3:0] wait_cnt;
  logic       pend;
  // single byte transfers, source steps by one, fixed destination
  // the bench sets an even count; lag makes the channel slow
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sent <= 8'h00;
      pend <= 1'b0;
      wait_cnt <= 4'h0;
      dma_write <= 1'b0;
      dma_wdata <= 8'h00;
    end else begin
      dma_write <= 1'b0;
      dma_wdata <= ~dma_wdata; // Idle data toggles each cycle, so it equals the last byte every other cycle
      if (!armed) sent <= 8'h00;
      if (armed && dma_trigger && dma_trigger_select == DMA_TRIGGER_CODE && sent < count) begin
        pend <= 1'b1;
        wait_cnt <= lag;
      end else if (pend && wait_cnt != 4'h0) begin
        wait_cnt <= wait_cnt - 4'h1;
      end else if (pend) begin
        pend <= 1'b0;
        dma_write <= 1'b1;
        dma_wdata <= 8'hA0 + sent;
        sent <= sent + 8'h01;
      end
    end
  end
endmodule : fwp_dma_model

/* fwp_controller_bench.sv */
`timescale 1ns/1ns
module fwp_controller_bench;
  import fwp_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, b_write = 1'b0, reg_read = 1'b0, cpu_fetch = 1'b0;
  logic [2:0] b_addr = 3'h0, cpu_clock_divider = 3'h0;
  logic [7:0] b_wdata = 8'h00, reg_rdata, cpu_fetch_data, dma_trigger_select, dma_wdata, rv;
  logic [15:0] cpu_byte_addr = 16'h0000;
  logic cpu_fetch_valid, dma_trigger, array_powered, nvm_busy, word_program_pending;
  logic armed = 1'b0, dma_write;
  logic [3:0] dma_lag = 4'h0;
  logic [7:0] dma_count = 8'h00;
  int checked = 0, mismatches = 0;
  // Channel writes always go to the data port
  wire reg_write = b_write | dma_write;
  wire [2:0] reg_addr = dma_write ? ADDR_DATA : b_addr;
  wire [7:0] reg_wdata = dma_write ? dma_wdata : b_wdata;
  always #20 clk = ~clk;
  fwp_controller #(.PAGES(32), .PAGE_ERASE_CNT(20), .CHIP_ERASE_CNT(40), .DATA_TIMEOUT_CNT(50))
  DUT (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .cpu_clock_divider(cpu_clock_divider), .cpu_fetch(cpu_fetch), .cpu_byte_addr(cpu_byte_addr),
    .cpu_fetch_data(cpu_fetch_data), .cpu_fetch_valid(cpu_fetch_valid),
    .dma_trigger(dma_trigger), .dma_trigger_select(dma_trigger_select),
    .array_powered(array_powered), .nvm_busy(nvm_busy), .word_program_pending(word_program_pending));
  fwp_dma_model u_dma (.clk(clk), .resetn(resetn), .dma_trigger(dma_trigger),
    .dma_trigger_select(dma_trigger_select), .armed(armed), .lag(dma_lag), .count(dma_count),
    .dma_write(dma_write), .dma_wdata(dma_wdata));
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    b_addr <= a;
    b_wdata <= d;
    b_write <= 1'b1;
    @(posedge clk);
    b_write <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    b_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 chk("register", {8'h00, reg_rdata}, {8'h00, exp});
  endtask : rd
  task automatic fetch(input logic [15:0] a, input logic [7:0] exp);
    int n = 0;
    @(posedge clk);
    cpu_byte_addr <= a;
    cpu_fetch <= 1'b1;
    do begin @(posedge clk); #1 n++; end while (cpu_fetch_valid !== 1'b1 && n < 20);
    chk("fetch valid", {15'h0, cpu_fetch_valid}, 16'h0001);
    chk("fetch", {8'h00, cpu_fetch_data}, {8'h00, exp});
    @(posedge clk);
    cpu_fetch <= 1'b0;
  endtask : fetch
  // Bounded wait for pending (pend=1) or busy to drop
  task automatic wait_low(input bit pend);
    int n = 0;
    do begin @(posedge clk); #1 n++; end
      while ((pend ? word_program_pending : nvm_busy) !== 1'b0 && n < 2000);
    chk("flag low", {15'h0, pend ? word_program_pending : nvm_busy}, 16'h0000);
  endtask : wait_low
  // One word: low byte then high byte, a fetch tried while it programs
  task automatic pair(input logic [7:0] lo, input logic [7:0] hi);
    wr(ADDR_DATA, lo);
    wr(ADDR_DATA, hi);
    @(posedge clk);
    cpu_fetch <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("pending", {15'h0, word_program_pending}, 16'h0001);
    chk("fetch valid", {15'h0, cpu_fetch_valid}, 16'h0000);
    @(posedge clk);
    cpu_fetch <= 1'b0;
    wait_low(1'b1);
  endtask : pair
  task automatic start(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] ctl);
    wr(ADDR_HIGH, hi);
    wr(ADDR_LOW, lo);
    wr(ADDR_CONTROL, ctl);
  endtask : start
  task automatic t_reset();
    rd(ADDR_CONTROL, 8'h00);
    chk("trigger code", {8'h00, dma_trigger_select}, {8'h00, DMA_TRIGGER_CODE});
    $display("test reset done");
  endtask : t_reset
  task automatic t_program();
    start(8'h05, 8'hFF, 8'h02);
    pair(8'h34, 8'h12);
    pair(8'hFF, 8'hF0);
    wait_low(1'b0);
    rd(ADDR_HIGH, 8'h06);
    rd(ADDR_LOW, 8'h01);
    fetch(16'h0BFE, 8'h34);
    fetch(16'h0BFF, 8'h12);
    fetch(16'h0C01, 8'hF0);
    start(8'h05, 8'hFF, 8'h02);
    pair(8'h0F, 8'hF0);
    wait_low(1'b0);
    fetch(16'h0BFE, 8'h04);
    fetch(16'h0BFF, 8'h10);
    $display("test program done");
  endtask : t_program
  task automatic t_erase();
    start(8'h04, 8'h00, 8'h01);
    wait_low(1'b0);
    fetch(16'h0BFE, 8'hFF);
    fetch(16'h0C01, 8'hF0);
    start(8'h06, 8'h00, 8'h03);
    // Data bytes are ignored until the erase part has finished
    repeat (24) @(posedge clk);
    pair(8'h55, 8'hAA);
    wait_low(1'b0);
    fetch(16'h0C00, 8'h55);
    fetch(16'h0C01, 8'hAA);
    $display("test erase done");
  endtask : t_erase
  task automatic t_dma();
    @(posedge clk);
    armed <= 1'b1;
    dma_lag <= 4'h9;
    dma_count <= 8'h04;
    // first trigger from one control write
    start(8'h01, 8'h00, 8'h02);
    wait_low(1'b0);
    @(posedge clk);
    armed <= 1'b0;
    fetch(16'h0200, 8'hA0);
    fetch(16'h0201, 8'hA1);
    fetch(16'h0203, 8'hA3);
    $display("test dma done");
  endtask : t_dma
  // Violation flag, debug chip erase and array power-down
  task automatic t_misc();
    rd(ADDR_MISC, 8'h04);
    wr(ADDR_MISC, 8'h04);
    rd(ADDR_MISC, 8'h00);
    wr(ADDR_MISC, 8'h01);
    rd(ADDR_MISC, 8'h01);
    wait_low(1'b0);
    fetch(16'h0C00, 8'hFF);
    @(posedge clk);
    cpu_clock_divider <= 3'h1;
    repeat (2) @(posedge clk);
    #1 chk("powered", {15'h0, array_powered}, 16'h0000);
    @(posedge clk);
    cpu_clock_divider <= 3'h0;
    repeat (2) @(posedge clk);
    #1 chk("powered", {15'h0, array_powered}, 16'h0001);
    $display("test misc done");
  endtask : t_misc
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  // Watchdog well above the expected run of about 3500 cycles
  initial begin
    #(40 * 40000);
    mismatches++;
    end_of_test();
  end
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_program();
    t_erase();
    t_dma();
    t_misc();
    end_of_test();
  end
endmodule : fwp_controller_bench
